// File: hw/ptts_params.svh
// constants for the talk arbitration and transmit/receive sequencer
// assumes a 100 MHz clock and a word-wide register port
`ifndef PTTS_PARAMS_SVH
`define PTTS_PARAMS_SVH

`define PTTS_CLK_PERIOD_NS 10
`define PTTS_ADDR_W 8
`define PTTS_DATA_W 32
`define PTTS_CNT_W 16
`define PTTS_SYNC_W 4

// register byte offsets
`define PTTS_OFS_CTRL 8'h00
`define PTTS_OFS_LEAD 8'h04
`define PTTS_OFS_HOLD 8'h08
`define PTTS_OFS_STATUS 8'h0C

// control fields
`define PTTS_CTRL_TALK_BIT 0
`define PTTS_CTRL_SER_DIS_BIT 1
`define PTTS_CTRL_RST 2'h2

// status fields
`define PTTS_STAT_SENSE_BIT 0
`define PTTS_STAT_TX_BIT 1
`define PTTS_STAT_RX_BIT 2
`define PTTS_STAT_AGC_BIT 3
`define PTTS_STAT_STATE_LSB 4

// default lead and hold times
`define PTTS_LEAD_TIME_NS 1000
`define PTTS_HOLD_TIME_NS 5000
`define PTTS_LEAD_CYC ((`PTTS_LEAD_TIME_NS + `PTTS_CLK_PERIOD_NS - 1) / `PTTS_CLK_PERIOD_NS)
`define PTTS_HOLD_CYC ((`PTTS_HOLD_TIME_NS + `PTTS_CLK_PERIOD_NS - 1) / `PTTS_CLK_PERIOD_NS)

`endif

// File: hw/ptts_pkg.sv
// types shared by the sequencer files
// assumes ptts_params.svh is compiled alongside
package ptts_pkg;

   typedef enum logic [3:0] {
      ST_RX = 4'h1,
      ST_MUTE = 4'h2,
      ST_TX = 4'h4,
      ST_HOLD = 4'h8
   } ptts_state_e;

endpackage

// File: hw/ptts_sequencer.sv
// talk arbitration and transmit/receive sequencer
// assumes request pins are asynchronous; register port on clock_i
//
// Function
// - transmitter enable output is active low
// - mic, keyer, serial requests ORed into sense
// - serial disable bit blocks the serial request
// - talk bit or keyer request enables transmitter
// - receiver muted before transmitter turns on
// - receiver stays muted while RF decays after
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "ptts_params.svh"

module ptts_sequencer (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic mic_talk_request_n_i,
   input wire logic keyer_talk_request_i,
   input wire logic serial_dtr_i,
   input wire logic keyer_rx_enable_i,
   input wire logic [`PTTS_ADDR_W-1:0] reg_addr_i,
   input wire logic [`PTTS_DATA_W-1:0] reg_wdata_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   output logic [`PTTS_DATA_W-1:0] reg_rdata_o,
   output logic talk_request_sense_o,
   output logic tx_enable_n_o,
   output logic rx_enable_o,
   output logic agc_hold_o
);

   logic [`PTTS_SYNC_W-1:0] pins_async;
   logic [`PTTS_SYNC_W-1:0] pins_sync;
   logic mic_s;
   logic keyer_s;
   logic dtr_s;
   logic keyer_rx_s;

   // mic line is inverted ahead of the synchroniser so all stages idle low
   assign pins_async = {keyer_rx_enable_i, serial_dtr_i, keyer_talk_request_i,
                        ~mic_talk_request_n_i};

   ptts_sync u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .async_i(pins_async),
      .sync_o(pins_sync)
   );

   assign mic_s = pins_sync[0];
   assign keyer_s = pins_sync[1];
   assign dtr_s = pins_sync[2];
   assign keyer_rx_s = pins_sync[3];

   // register port
   logic [1:0] ctrl_q;
   logic [`PTTS_CNT_W-1:0] lead_q;
   logic [`PTTS_CNT_W-1:0] hold_q;
   logic [`PTTS_DATA_W-1:0] rdata_q;
   logic [`PTTS_DATA_W-1:0] rdata_d;
   logic sel_ctrl;
   logic sel_lead;
   logic sel_hold;
   logic sel_status;
   logic talk_bit;
   logic ser_dis;

   assign sel_ctrl = (reg_addr_i == `PTTS_OFS_CTRL);
   assign sel_lead = (reg_addr_i == `PTTS_OFS_LEAD);
   assign sel_hold = (reg_addr_i == `PTTS_OFS_HOLD);
   assign sel_status = (reg_addr_i == `PTTS_OFS_STATUS);
   assign talk_bit = ctrl_q[`PTTS_CTRL_TALK_BIT];
   assign ser_dis = ctrl_q[`PTTS_CTRL_SER_DIS_BIT];

   // serial disable comes up set so a host raising its line at boot cannot assert the sensed talk request
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         ctrl_q <= `PTTS_CTRL_RST;
         lead_q <= `PTTS_CNT_W'(`PTTS_LEAD_CYC);
         hold_q <= `PTTS_CNT_W'(`PTTS_HOLD_CYC);
      end else if (reg_write_i) begin
         if (sel_ctrl) begin
            ctrl_q <= reg_wdata_i[1:0];
         end
         if (sel_lead) begin
            lead_q <= reg_wdata_i[`PTTS_CNT_W-1:0];
         end
         if (sel_hold) begin
            hold_q <= reg_wdata_i[`PTTS_CNT_W-1:0];
         end
      end
   end

   // sense and sequencing
   logic sense_q;
   logic sense_d;
   logic tx_demand;
   ptts_pkg::ptts_state_e state_q;
   ptts_pkg::ptts_state_e state_d;
   logic [`PTTS_CNT_W-1:0] cnt_q;
   logic [`PTTS_CNT_W-1:0] cnt_d;
   logic cnt_done;
   logic tx_n_q;
   logic rx_en_q;
   logic agc_q;

   assign sense_d = mic_s | keyer_s | (dtr_s & ~ser_dis);
   assign tx_demand = talk_bit | keyer_s;
   assign cnt_done = (cnt_q == '0);

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_done ? cnt_q : cnt_q - `PTTS_CNT_W'(1);
      case (state_q)
         ptts_pkg::ST_RX: begin
            if (tx_demand) begin
               state_d = ptts_pkg::ST_MUTE;
               cnt_d = lead_q;
            end
         end
         ptts_pkg::ST_MUTE: begin
            if (!tx_demand) begin
               state_d = ptts_pkg::ST_RX;
            end else if (cnt_done) begin
               state_d = ptts_pkg::ST_TX;
            end
         end
         ptts_pkg::ST_TX: begin
            if (!tx_demand) begin
               state_d = ptts_pkg::ST_HOLD;
               cnt_d = hold_q;
            end
         end
         ptts_pkg::ST_HOLD: begin
            // receiver still muted, so a new request may key again at once
            if (tx_demand) begin
               state_d = ptts_pkg::ST_TX;
            end else if (cnt_done) begin
               state_d = ptts_pkg::ST_RX;
            end
         end
         default: begin
            state_d = ptts_pkg::ST_RX;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_q <= ptts_pkg::ST_RX;
         cnt_q <= '0;
         sense_q <= 1'b0;
         tx_n_q <= 1'b1;
         rx_en_q <= 1'b0;
         agc_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         sense_q <= sense_d;
         tx_n_q <= (state_d != ptts_pkg::ST_TX);
         // keyer decides when to listen; we only veto outside idle receive
         rx_en_q <= keyer_rx_s & (state_d == ptts_pkg::ST_RX);
         agc_q <= (state_d != ptts_pkg::ST_RX);
      end
   end

   assign talk_request_sense_o = sense_q;
   assign tx_enable_n_o = tx_n_q;
   assign rx_enable_o = rx_en_q;
   assign agc_hold_o = agc_q;

   // read data valid only in the cycle after the strobe; unmapped reads zero
   always_comb begin
      rdata_d = '0;
      if (reg_read_i) begin
         if (sel_ctrl) begin
            rdata_d[1:0] = ctrl_q;
         end else if (sel_lead) begin
            rdata_d[`PTTS_CNT_W-1:0] = lead_q;
         end else if (sel_hold) begin
            rdata_d[`PTTS_CNT_W-1:0] = hold_q;
         end else if (sel_status) begin
            rdata_d[`PTTS_STAT_SENSE_BIT] = sense_q;
            rdata_d[`PTTS_STAT_TX_BIT] = ~tx_n_q;
            rdata_d[`PTTS_STAT_RX_BIT] = rx_en_q;
            rdata_d[`PTTS_STAT_AGC_BIT] = agc_q;
            rdata_d[`PTTS_STAT_STATE_LSB +: 4] = state_q;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // checks
   logic [`PTTS_CNT_W:0] off_cnt_q;

   // cycles the transmitter has been off, saturating; starts full since nothing keyed before
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         off_cnt_q <= '1;
      end else if (!tx_n_q) begin
         off_cnt_q <= '0;
      end else if (off_cnt_q != '1) begin
         off_cnt_q <= off_cnt_q + (`PTTS_CNT_W+1)'(1);
      end
   end

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   sequence s_tx_start;
      $fell(tx_enable_n_o);
   endsequence

   sequence s_rx_muted_two;
      !rx_enable_o && $past(!rx_enable_o);
   endsequence

   chk_tx_low_active: assert property (
      tx_enable_n_o == (state_q != ptts_pkg::ST_TX))
      else $error("transmitter enable level disagrees with state");

   chk_sense_wired_or: assert property (
      ##1 talk_request_sense_o == $past(mic_s | keyer_s | (dtr_s & ~ser_dis)))
      else $error("sensed request is not the or of the requests");

   chk_serial_blocked: assert property (
      (ser_dis && !mic_s && !keyer_s) |=> !talk_request_sense_o)
      else $error("serial request passed while disabled");

   chk_demand_keys: assert property (
      (state_q == ptts_pkg::ST_MUTE && cnt_done && tx_demand) |=> !tx_enable_n_o)
      else $error("transmitter not enabled on demand after lead time");

   chk_mute_first: assert property (
      s_tx_start |-> s_rx_muted_two)
      else $error("receiver not muted ahead of transmit");

   chk_unmute_delay: assert property (
      $rose(rx_enable_o) |-> (off_cnt_q > {1'b0, hold_q}) && agc_hold_o == 1'b0)
      else $error("receiver unmuted before hold time");

   chk_lead_count: assert property (
      (state_q == ptts_pkg::ST_MUTE && !cnt_done && tx_demand) |=> tx_enable_n_o)
      else $error("transmitter keyed before lead count expired");

   chk_read_timing: assert property (
      !reg_read_i |=> reg_rdata_o == '0)
      else $error("read data present without a read strobe");

endmodule

// File: hw/ptts_sync.sv
// two-flop synchroniser for the asynchronous request pins
// assumes inputs are already active high and idle low
`timescale 1ns/1ps
`include "ptts_params.svh"

module ptts_sync (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [`PTTS_SYNC_W-1:0] async_i,
   output logic [`PTTS_SYNC_W-1:0] sync_o
);

   logic [`PTTS_SYNC_W-1:0] meta_q;
   logic [`PTTS_SYNC_W-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

// File: testbench/ptts_keyer_model.sv
// behavioural keyer processor driving the talk request and listen wish
// assumes commands come from the bench, synchronous to clock_i
`timescale 1ns/1ps

module ptts_keyer_model (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic talk_cmd_i,
   input wire logic listen_cmd_i,
   output logic keyer_talk_request_o,
   output logic keyer_rx_enable_o
);
   initial begin
      keyer_talk_request_o = 1'b0;
      keyer_rx_enable_o = 1'b0;
   end
   always @(posedge clock_i) begin
      keyer_talk_request_o <= talk_cmd_i & ~rst_i;
      // keyer drops its listen wish while it talks, as a real keyer would
      keyer_rx_enable_o <= listen_cmd_i & ~talk_cmd_i & ~rst_i;
   end
endmodule

// File: testbench/tb_ptts_sequencer.sv
// self-checking bench for the talk sequencer
// assumes the keyer model and the design files are compiled first
`timescale 1ns/1ps
`include "ptts_params.svh"

module tb_ptts_sequencer;
   logic clock_i, rst_i, mic_n, dtr, talk_cmd, listen_cmd, wr, rd;
   logic [`PTTS_ADDR_W-1:0] addr;
   logic [`PTTS_DATA_W-1:0] wdata, rdata, got;
   logic sense, tx_n, rx_en, agc, k_talk, k_rx;
   int miscompares = 0;
   int n_tests = 0;
   int n;

   ptts_keyer_model keyer (.clock_i(clock_i), .rst_i(rst_i), .talk_cmd_i(talk_cmd),
      .listen_cmd_i(listen_cmd), .keyer_talk_request_o(k_talk), .keyer_rx_enable_o(k_rx));
   ptts_sequencer uut (.clock_i(clock_i), .rst_i(rst_i), .mic_talk_request_n_i(mic_n),
      .keyer_talk_request_i(k_talk), .serial_dtr_i(dtr), .keyer_rx_enable_i(k_rx),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd),
      .reg_rdata_o(rdata), .talk_request_sense_o(sense), .tx_enable_n_o(tx_n),
      .rx_enable_o(rx_en), .agc_hold_o(agc));

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic print_verdict();
      if (miscompares == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // counts edges until the chosen output (0 tx_n, 1 rx_en) shows val
   task automatic wait_sig(input int which, input logic val, output int cnt);
      cnt = 0;
      while ((((which != 0) ? rx_en : tx_n) !== val) && cnt < 2000) begin
         @(posedge clock_i);
         #1 cnt++;
      end
      if (((which != 0) ? rx_en : tx_n) !== val) begin
         miscompares++;
         print_verdict();
      end
   endtask

   task automatic cycles(input int c);
      repeat (c) @(posedge clock_i);
      #1;
   endtask

   initial begin
      rst_i = 1'b1;
      mic_n = 1'b1;
      dtr = 1'b0;
      talk_cmd = 1'b0;
      listen_cmd = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      cycles(1);
      chk("tx_n reset", tx_n, 1);
      reg_rd(`PTTS_OFS_CTRL, got);
      chk("ctrl reset", got, 32'h2);
      reg_rd(`PTTS_OFS_LEAD, got);
      chk("lead reset", got, 32'h64);
      reg_rd(`PTTS_OFS_HOLD, got);
      chk("hold reset", got, 32'h1F4);
      reg_rd(8'h10, got);
      chk("unmapped", got, 32'h0);
      listen_cmd <= 1'b1;
      wait_sig(1, 1'b1, n);
      // serial request blocked at boot, passes once enabled
      dtr <= 1'b1;
      cycles(4);
      chk("dtr masked", sense, 0);
      reg_wr(`PTTS_OFS_CTRL, 32'h0);
      cycles(4);
      chk("dtr sense", sense, 1);
      dtr <= 1'b0;
      mic_n <= 1'b0;
      cycles(4);
      chk("mic sense", sense, 1);
      mic_n <= 1'b1;
      cycles(4);
      chk("sense idle", sense, 0);
      // short lead and hold so the sequence is counted exactly
      reg_wr(`PTTS_OFS_LEAD, 32'h2);
      reg_wr(`PTTS_OFS_HOLD, 32'h2);
      reg_wr(`PTTS_OFS_CTRL, 32'h1);
      wait_sig(1, 1'b0, n);
      chk("tx off in mute", tx_n, 1);
      wait_sig(0, 1'b0, n);
      chk("lead cycles", n, 3);
      reg_wr(`PTTS_OFS_CTRL, 32'h0);
      wait_sig(0, 1'b1, n);
      chk("rx muted in hold", rx_en, 0);
      chk("agc held in hold", agc, 1);
      wait_sig(1, 1'b1, n);
      chk("hold cycles", n, 3);
      chk("agc released", agc, 0);
      // demand dropped during the lead time: back to receive, never keyed
      reg_wr(`PTTS_OFS_LEAD, 32'h14);
      reg_wr(`PTTS_OFS_CTRL, 32'h1);
      reg_wr(`PTTS_OFS_CTRL, 32'h0);
      wait_sig(1, 1'b1, n);
      chk("mute abort cycles", n, 1);
      chk("mute abort tx", tx_n, 1);
      // demand back during the hold keys again at once, receiver still muted
      reg_wr(`PTTS_OFS_LEAD, 32'h2);
      reg_wr(`PTTS_OFS_HOLD, 32'h14);
      reg_wr(`PTTS_OFS_CTRL, 32'h1);
      wait_sig(0, 1'b0, n);
      reg_wr(`PTTS_OFS_CTRL, 32'h0);
      wait_sig(0, 1'b1, n);
      reg_wr(`PTTS_OFS_CTRL, 32'h1);
      wait_sig(0, 1'b0, n);
      chk("hold rekey cycles", n, 1);
      chk("hold rekey rx", rx_en, 0);
      reg_wr(`PTTS_OFS_CTRL, 32'h0);
      wait_sig(0, 1'b1, n);
      wait_sig(1, 1'b1, n);
      chk("long hold cycles", n, 21);
      // keyer alone keys the transmitter and shows in status
      talk_cmd <= 1'b1;
      wait_sig(0, 1'b0, n);
      chk("keyer tx rx", rx_en, 0);
      reg_rd(`PTTS_OFS_STATUS, got);
      chk("status tx", got, {24'h0, ptts_pkg::ST_TX, 4'hB});
      talk_cmd <= 1'b0;
      wait_sig(1, 1'b1, n);
      chk("tx_n after", tx_n, 1);
      print_verdict();
   end
endmodule
